// ---- qsf_pkg.sv ----
// Shared constants and types for the quad serial flash port.
package qsf_pkg;

  localparam int QSF_DATA_W        = 8;
  localparam int QSF_FIFO_DEPTH    = 8;
  localparam int QSF_SYNC_STAGES   = 2;
  localparam int QSF_PAGE_BYTES    = 256;
  localparam int QSF_SECTOR_BYTES  = 4096;
  localparam int QSF_BLOCK_BYTES   = 65536;
  localparam int QSF_ARRAY_ADDR_W  = 20;
  localparam int QSF_ADDR_BYTES    = 3;
  localparam int QSF_QE_POS        = 6;
  localparam int QSF_LOCK_POS      = 7;
  localparam logic [7:0] QSF_STATUS_RESET   = 8'h00;
  localparam logic [7:0] QSF_STATUS_WR_MASK = 8'hFC;

  // Number of data lines used per serial clock edge.
  typedef enum logic [1:0] {QSF_LANE_SINGLE, QSF_LANE_DUAL, QSF_LANE_QUAD} qsf_lane_type;

  // Granularity of an erase request.
  typedef enum logic [1:0] {QSF_ERASE_SECTOR, QSF_ERASE_BLOCK, QSF_ERASE_CHIP} qsf_erase_type;

  // Position inside one selected frame.
  typedef enum logic [1:0] {QSF_PH_CMD, QSF_PH_ADDR, QSF_PH_DATA} qsf_phase_type;

endpackage : qsf_pkg

// ---- qsf_sync.sv ----
// Two flip-flop synchroniser for pins that arrive from outside the clock domain.
module qsf_sync
  import qsf_pkg::*;
#(
  parameter int WIDTH = 6
)
(
  input  wire logic             clock_in,
  input  wire logic             srst_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } qsf_sync_state_type;

  qsf_sync_state_type state;
  qsf_sync_state_type next_state;

  // The first stage feeds only the second stage, never any logic.
  always_comb
  begin
    next_state.first  = async_in;
    next_state.second = state.first;
  end

  // Registers both stages together.
  always_ff @(posedge clock_in)
  begin
    if (srst_in)
      state <= '0;
    else
      state <= next_state;
  end

  assign sync_out = state.second;

endmodule : qsf_sync

// ---- qsf_fifo.sv ----
// Flip-flop FIFO with valid and ready on both sides and a registered head.
module qsf_fifo
  import qsf_pkg::*;
#(
  parameter int WIDTH = QSF_DATA_W,
  parameter int DEPTH = QSF_FIFO_DEPTH
)
(
  input  wire logic             clock_in,
  input  wire logic             srst_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  output logic      [WIDTH-1:0] out_data_out,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // Pointers wrap by overflow, so the depth must be a power of two.
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
  begin : g_bad_param
    $error("qsf_fifo depth must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               rd;
    logic [AW-1:0]               wr;
    logic [AW:0]                 count;
    logic                        out_valid;
    logic [WIDTH-1:0]            out_data;
  } qsf_fifo_state_type;

  qsf_fifo_state_type state;
  qsf_fifo_state_type next_state;
  logic               push;
  logic               pop;

  // Full stalls the writer; the head copy keeps the output on a flip-flop.
  always_comb
  begin
    next_state = state;
    push = in_valid_in && (state.count != (AW+1)'(DEPTH));
    pop  = state.out_valid && out_ready_in;
    if (push)
    begin
      next_state.mem[state.wr] = in_data_in;
      next_state.wr = state.wr + 1'b1;
    end
    if (pop)
      next_state.rd = state.rd + 1'b1;
    next_state.count = state.count + (AW+1)'(push) - (AW+1)'(pop);
    next_state.out_valid = (next_state.count != '0);
    if (push && (state.count == '0 || (pop && state.count == (AW+1)'(1))))
      next_state.out_data = in_data_in;
    else
      next_state.out_data = state.mem[next_state.rd];
  end

  // Registers the whole FIFO state.
  always_ff @(posedge clock_in)
  begin
    if (srst_in)
      state <= '0;
    else
      state <= next_state;
  end

  assign in_ready_out  = (state.count != (AW+1)'(DEPTH));
  assign out_valid_out = state.out_valid;
  assign out_data_out  = state.out_data;

endmodule : qsf_fifo

// ---- qsf_flash_port.sv ----
// Device-side serial front end of a quad SPI page-programmable flash.
module qsf_flash_port
  import qsf_pkg::*;
#(
  parameter int FIFO_DEPTH = QSF_FIFO_DEPTH
)
(
  input  wire logic          clock_in,
  input  wire logic          srst_in,
  input  wire logic          sck_in,
  input  wire logic          cs_n_in,
  input  wire logic          data_line_zero_in,
  output logic               data_line_zero_out,
  output logic               data_line_zero_oe_out,
  input  wire logic          data_line_one_in,
  output logic               data_line_one_out,
  output logic               data_line_one_oe_out,
  input  wire logic          data_line_two_in,
  output logic               data_line_two_out,
  output logic               data_line_two_oe_out,
  input  wire logic          data_line_three_in,
  output logic               data_line_three_out,
  output logic               data_line_three_oe_out,
  input  wire qsf_lane_type  lane_mode_in,
  input  wire logic          tx_active_in,
  input  wire logic [7:0]    tx_data_in,
  input  wire logic          tx_valid_in,
  output logic               tx_ready_out,
  output logic      [7:0]    rx_data_out,
  output logic               rx_valid_out,
  input  wire logic          rx_ready_in,
  output logic      [7:0]    cmd_out,
  output logic               cmd_valid_out,
  output logic      [23:0]   addr_out,
  output logic               addr_valid_out,
  output logic      [23:0]   program_address_out,
  output logic      [8:0]    program_count_out,
  output logic               overrun_out,
  input  wire logic          status_write_in,
  input  wire logic [7:0]    status_wdata_in,
  output logic      [7:0]    status_out,
  output logic               write_protect_out,
  output logic               status_write_ignored_out,
  input  wire logic          erase_req_in,
  input  wire qsf_erase_type erase_kind_in,
  input  wire logic [19:0]   erase_addr_in,
  output logic      [19:0]   erase_first_out,
  output logic      [19:0]   erase_last_out,
  output logic               erase_valid_out,
  output logic               standby_out,
  output logic               paused_out
);

  if (FIFO_DEPTH < 2)
  begin : g_bad_depth
    $error("qsf_flash_port needs a FIFO depth of at least 2");
  end

  typedef struct packed {
    logic          sck_prev;
    logic          cs_n_prev;
    logic          armed;
    logic          rose;
    qsf_phase_type phase;
    logic [1:0]    addr_left;
    logic [2:0]    bit_cnt;
    logic [7:0]    rx_shift;
    logic [2:0]    tx_cnt;
    logic [7:0]    tx_shift;
    logic          tx_ready;
    logic [3:0]    line_out;
    logic [3:0]    line_oe;
    logic [7:0]    cmd;
    logic          cmd_valid;
    logic [23:0]   addr;
    logic          addr_valid;
    logic [7:0]    page_offset;
    logic [8:0]    prog_count;
    logic          push;
    logic [7:0]    push_data;
    logic          overrun;
    logic [7:0]    status;
    logic          write_protect;
    logic          write_ignored;
    logic [19:0]   erase_first;
    logic [19:0]   erase_last;
    logic          erase_valid;
    logic          standby;
    logic          paused;
  } qsf_state_type;

  qsf_state_type state;
  qsf_state_type next_state;
  logic [5:0]    pins_sync;
  logic          fifo_in_ready;

  // Bits moved per clock edge in each lane mode.
  function automatic logic [3:0] lane_step(input qsf_lane_type lane);
    unique case (lane)
      QSF_LANE_SINGLE: lane_step = 4'h1;
      QSF_LANE_DUAL:   lane_step = 4'h2;
      QSF_LANE_QUAD:   lane_step = 4'h4;
      default:         lane_step = 4'h1;
    endcase
  endfunction : lane_step

  // Output enables of the lines that carry read data in each mode.
  function automatic logic [3:0] lane_oe(input qsf_lane_type lane);
    unique case (lane)
      QSF_LANE_SINGLE: lane_oe = 4'h2;
      QSF_LANE_DUAL:   lane_oe = 4'h3;
      QSF_LANE_QUAD:   lane_oe = 4'hF;
      default:         lane_oe = 4'h2;
    endcase
  endfunction : lane_oe

  // Byte-address mask covering one erase unit.
  function automatic logic [19:0] erase_mask(input qsf_erase_type kind);
    unique case (kind)
      QSF_ERASE_SECTOR: erase_mask = 20'(QSF_SECTOR_BYTES - 1);
      QSF_ERASE_BLOCK:  erase_mask = 20'(QSF_BLOCK_BYTES - 1);
      QSF_ERASE_CHIP:   erase_mask = 20'hFFFFF;
      default:          erase_mask = 20'(QSF_SECTOR_BYTES - 1);
    endcase
  endfunction : erase_mask

  // Clock, select and all four data lines come from the host's domain.
  qsf_sync #(
    .WIDTH (6)
  ) u_sync (
    .clock_in (clock_in),
    .srst_in  (srst_in),
    .async_in ({data_line_three_in, data_line_two_in, data_line_one_in,
                data_line_zero_in, cs_n_in, sck_in}),
    .sync_out (pins_sync)
  );

  // Received data bytes wait here until the user side takes them.
  qsf_fifo #(
    .WIDTH (QSF_DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .clock_in      (clock_in),
    .srst_in       (srst_in),
    .in_data_in    (state.push_data),
    .in_valid_in   (state.push),
    .in_ready_out  (fifo_in_ready),
    .out_data_out  (rx_data_out),
    .out_valid_out (rx_valid_out),
    .out_ready_in  (rx_ready_in)
  );

  // Frame sequencing, shifting, pin drive and status handling.
  always_comb
  begin
    logic         sck_s;
    logic         cs_n_s;
    logic [3:0]   lines_s;
    logic         qe;
    logic         selected;
    logic         active;
    logic         wp_low;
    qsf_lane_type lane;
    logic [3:0]   step;
    logic [3:0]   rx_bits;
    logic [7:0]   rx_byte;
    logic [7:0]   tx_byte;
    logic         byte_done;
    sck_s     = pins_sync[0];
    cs_n_s    = pins_sync[1];
    lines_s   = pins_sync[5:2];
    qe        = state.status[QSF_QE_POS];
    selected  = !cs_n_s;
    lane      = QSF_LANE_SINGLE;
    step      = 4'h1;
    rx_bits   = 4'h0;
    rx_byte   = 8'h00;
    tx_byte   = 8'h00;
    byte_done = 1'b0;

    next_state               = state;
    next_state.sck_prev      = sck_s;
    next_state.cs_n_prev     = cs_n_s;
    next_state.cmd_valid     = 1'b0;
    next_state.addr_valid    = 1'b0;
    next_state.push          = 1'b0;
    next_state.tx_ready      = 1'b0;
    next_state.erase_valid   = 1'b0;
    next_state.write_ignored = 1'b0;

    // Pause and protect only exist while quad mode is off.
    next_state.paused = selected && !qe && !lines_s[3];
    wp_low = !qe && !lines_s[2];
    next_state.write_protect = wp_low;
    active = selected && state.armed && !next_state.paused;

    // Quad transfers need the enable bit; otherwise fall back to one line.
    if (lane_mode_in == QSF_LANE_QUAD && !qe)
      lane = QSF_LANE_SINGLE;
    else
      lane = lane_mode_in;
    step = lane_step(lane);

    // Selection arms the port; the flag is cleared on selection, set wins.
    if (state.cs_n_prev && !cs_n_s)
    begin
      next_state.armed   = 1'b1;
      next_state.overrun = 1'b0;
    end
    if (state.push && !fifo_in_ready)
      next_state.overrun = 1'b1;

    if (!state.cs_n_prev && cs_n_s)
    begin
      // Deselection closes the frame so the next one starts at an opcode.
      next_state.phase     = QSF_PH_CMD;
      next_state.bit_cnt   = 3'h0;
      next_state.tx_cnt    = 3'h0;
      next_state.addr_left = 2'h0;
      next_state.rose      = 1'b0;
    end
    else if (active && !state.sck_prev && sck_s)
    begin
      // Rising clock edge: capture 1, 2 or 4 bits, highest lane first.
      unique case (lane)
        QSF_LANE_SINGLE: rx_bits = {3'h0, lines_s[0]};
        QSF_LANE_DUAL:   rx_bits = {2'h0, lines_s[1:0]};
        QSF_LANE_QUAD:   rx_bits = lines_s;
        default:         rx_bits = {3'h0, lines_s[0]};
      endcase
      rx_byte = 8'(state.rx_shift << step) | {4'h0, rx_bits};
      byte_done = ({1'b0, state.bit_cnt} + step) == 4'h8;
      next_state.rx_shift = rx_byte;
      next_state.bit_cnt  = state.bit_cnt + step[2:0];
      next_state.rose     = 1'b1;
      if (byte_done)
      begin
        unique case (state.phase)
          QSF_PH_CMD:
          begin
            next_state.cmd       = rx_byte;
            next_state.cmd_valid = 1'b1;
            next_state.phase     = QSF_PH_ADDR;
            next_state.addr_left = 2'(QSF_ADDR_BYTES - 1);
          end
          QSF_PH_ADDR:
          begin
            next_state.addr = {state.addr[15:0], rx_byte};
            if (state.addr_left == 2'h0)
            begin
              next_state.phase       = QSF_PH_DATA;
              next_state.addr_valid  = 1'b1;
              next_state.page_offset = rx_byte;
              next_state.prog_count  = 9'h000;
            end
            else
              next_state.addr_left = state.addr_left - 2'h1;
          end
          QSF_PH_DATA:
          begin
            next_state.push      = !tx_active_in;
            next_state.push_data = rx_byte;
            // Program address wraps inside its page; count stops at a page.
            next_state.page_offset = state.page_offset + 8'h01;
            if (state.prog_count != 9'(QSF_PAGE_BYTES))
              next_state.prog_count = state.prog_count + 9'h001;
          end
          default:
            next_state.phase = QSF_PH_CMD;
        endcase
      end
    end
    else if (active && state.rose && tx_active_in && state.sck_prev && !sck_s)
    begin
      // Falling clock edge after a capture: present the next 1, 2 or 4 bits.
      // Waiting for a capture keeps an idle-high clock from shifting early.
      if (state.tx_cnt == 3'h0)
      begin
        tx_byte = tx_valid_in ? tx_data_in : 8'h00;
        next_state.tx_ready = tx_valid_in;
      end
      else
        tx_byte = state.tx_shift;
      unique case (lane)
        QSF_LANE_SINGLE: next_state.line_out = {2'h0, tx_byte[7], 1'b0};
        QSF_LANE_DUAL:   next_state.line_out = {2'h0, tx_byte[7:6]};
        QSF_LANE_QUAD:   next_state.line_out = tx_byte[7:4];
        default:         next_state.line_out = {2'h0, tx_byte[7], 1'b0};
      endcase
      next_state.tx_shift = 8'(tx_byte << step);
      next_state.tx_cnt   = state.tx_cnt + step[2:0];
    end

    // Lines are driven only while selected, unpaused and in a read phase.
    if (selected && state.armed && !next_state.paused && tx_active_in)
      next_state.line_oe = lane_oe(lane);
    else
      next_state.line_oe = 4'h0;
    next_state.standby = !selected;

    // Status writes are refused while locked and the protect pin is low.
    if (status_write_in)
    begin
      if (state.status[QSF_LOCK_POS] && wp_low)
        next_state.write_ignored = 1'b1;
      else
        next_state.status = status_wdata_in & QSF_STATUS_WR_MASK;
    end

    // Erase requests resolve to the first and last byte of their unit.
    if (erase_req_in)
    begin
      next_state.erase_first = erase_addr_in & ~erase_mask(erase_kind_in);
      next_state.erase_last  = erase_addr_in | erase_mask(erase_kind_in);
      next_state.erase_valid = 1'b1;
    end
  end

  // One register for the whole port state; nothing is armed after reset.
  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      state         <= '0;
      state.status  <= QSF_STATUS_RESET;
      state.standby <= 1'b1;
    end
    else
      state <= next_state;
  end

  // Every output but rx data and valid, which come from the FIFO, is built from fields of the registered state.
  assign data_line_zero_out       = state.line_out[0];
  assign data_line_one_out        = state.line_out[1];
  assign data_line_two_out        = state.line_out[2];
  assign data_line_three_out      = state.line_out[3];
  assign data_line_zero_oe_out    = state.line_oe[0];
  assign data_line_one_oe_out     = state.line_oe[1];
  assign data_line_two_oe_out     = state.line_oe[2];
  assign data_line_three_oe_out   = state.line_oe[3];
  assign tx_ready_out             = state.tx_ready;
  assign cmd_out                  = state.cmd;
  assign cmd_valid_out            = state.cmd_valid;
  assign addr_out                 = state.addr;
  assign addr_valid_out           = state.addr_valid;
  assign program_address_out      = {state.addr[23:8], state.page_offset};
  assign program_count_out        = state.prog_count;
  assign overrun_out              = state.overrun;
  assign status_out               = state.status;
  assign write_protect_out        = state.write_protect;
  assign status_write_ignored_out = state.write_ignored;
  assign erase_first_out          = state.erase_first;
  assign erase_last_out           = state.erase_last;
  assign erase_valid_out          = state.erase_valid;
  assign standby_out              = state.standby;
  assign paused_out               = state.paused;

endmodule : qsf_flash_port

// ---- qsf_host_model.sv ----
// Host model for the flash port.
module qsf_host_model
(
  input  wire logic       clock_in,
  input  wire logic [3:0] line_in,
  output logic            sck_out = 1'h0,
  output logic            cs_n_out = 1'h1,
  output logic      [3:0] oe_out = 4'h0,
  output logic      [3:0] val_out = 4'h0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic idle_hi = 1'h0;

  // Half a serial clock is four clocks.
  task automatic half();
    repeat (4) @(posedge clock_in);
  endtask : half

  // Select with the clock at its idle level.
  task automatic start();
    sck_out <= idle_hi;
    half();
    cs_n_out <= 1'h0;
    half();
  endtask : start

  // Deselect long enough to be seen.
  task automatic stop();
    half();
    sck_out <= idle_hi;
    half();
    cs_n_out <= 1'h1;
    oe_out <= 4'h0;
    half();
  endtask : stop

  // Shifts n bits MSB first; reads sample at the end of the high phase.
  task automatic xfer(input int lanes, input logic [7:0] b, input int n, input bit rd, output logic [7:0] got);
    logic [3:0] m;
    logic [7:0] s;
    m = 4'((1 << lanes) - 1);
    got = 8'h00;
    for (int i = 0; i < n; i += lanes)
    begin
      s = b << i;
      sck_out <= 1'h0;
      oe_out <= (oe_out & ~m) | (rd ? 4'h0 : m);
      val_out <= (val_out & ~m) | (s[7:4] >> (4 - lanes));
      half();
      sck_out <= 1'h1;
      half();
      got = (got << lanes) | 8'((lanes == 1) ? 4'(line_in[1]) : line_in & m);
    end
  endtask : xfer

  // Drives or releases one pin.
  task automatic set_pin(input int k, input logic v, input logic en);
    @(posedge clock_in);
    val_out[k] <= v;
    oe_out[k] <= en;
  endtask : set_pin
endmodule : qsf_host_model

// ---- qsf_flash_port_properties.sv ----
// Checker on the flash port.
module qsf_flash_port_props
  import qsf_pkg::*;
(
  input wire logic          clock_in,
  input wire logic          srst_in,
  input wire logic          cs_n_in,
  input wire logic          data_line_two_in,
  input wire logic          data_line_three_in,
  input wire logic          data_line_zero_oe_out,
  input wire logic          data_line_one_oe_out,
  input wire logic          data_line_two_oe_out,
  input wire logic          data_line_three_oe_out,
  input wire logic          cmd_valid_out,
  input wire logic          addr_valid_out,
  input wire logic          status_write_in,
  input wire logic [7:0]    status_wdata_in,
  input wire logic [7:0]    status_out,
  input wire logic          write_protect_out,
  input wire logic          status_write_ignored_out,
  input wire logic          erase_req_in,
  input wire qsf_erase_type erase_kind_in,
  input wire logic [19:0]   erase_addr_in,
  input wire logic [19:0]   erase_first_out,
  input wire logic [19:0]   erase_last_out,
  input wire logic          erase_valid_out,
  input wire logic          standby_out,
  input wire logic          paused_out
);
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (srst_in);

  // Pin paths lag three cycles, hence the late windows.
  idle_release_a: assert property (cs_n_in[*4] |-> !(data_line_zero_oe_out || data_line_one_oe_out
    || data_line_two_oe_out || data_line_three_oe_out)) else $error("Pins driven idle.");
  standby_flag_a: assert property (cs_n_in[*4] |-> standby_out) else $error("Standby missing.");
  deselect_quiet_a: assert property (cs_n_in[*6] |-> !cmd_valid_out && !addr_valid_out)
    else $error("Frame while idle.");
  pause_release_a: assert property ((!cs_n_in && !data_line_three_in && !status_out[6])[*4]
    |-> !data_line_one_oe_out) else $error("Driven while paused.");
  protect_level_a: assert property ((!data_line_two_in && !status_out[6])[*4] |-> write_protect_out)
    else $error("Protect flag missing.");
  quad_pins_a: assert property (status_out[6][*2] |-> !write_protect_out && !paused_out)
    else $error("Pin role kept in quad.");
  status_store_a: assert property (status_write_in && !(status_out[7] && write_protect_out)
    |=> status_out == ($past(status_wdata_in) & 8'hFC)) else $error("Status write lost.");
  status_lock_a: assert property (status_write_in && status_out[7] && write_protect_out
    |=> status_write_ignored_out && $stable(status_out)) else $error("Locked status changed.");
  sector_span_a: assert property (erase_req_in && erase_kind_in == QSF_ERASE_SECTOR |=> erase_valid_out
    && erase_first_out == {$past(erase_addr_in[19:12]), 12'h000} && erase_last_out == (erase_first_out | 20'h00FFF))
    else $error("Sector span wrong.");
endmodule : qsf_flash_port_props

bind qsf_flash_port qsf_flash_port_props u_props (.clock_in, .srst_in, .cs_n_in,
  .data_line_two_in, .data_line_three_in, .data_line_zero_oe_out, .data_line_one_oe_out, .data_line_two_oe_out,
  .data_line_three_oe_out, .cmd_valid_out, .addr_valid_out, .status_write_in, .status_wdata_in, .status_out,
  .write_protect_out, .status_write_ignored_out, .erase_req_in, .erase_kind_in, .erase_addr_in, .erase_first_out,
  .erase_last_out, .erase_valid_out, .standby_out, .paused_out);

// ---- qsf_tb.sv ----
// Bench for the flash port.
module tb
  import qsf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_in = 1'h0, srst_in = 1'h1, sck, cs_n, flip = 1'h0, hold_rx = 1'h0;
  logic [3:0] h_oe, h_val, d_oe, d_out, line;
  qsf_lane_type lane_mode_in = QSF_LANE_SINGLE;
  qsf_erase_type erase_kind_in = QSF_ERASE_SECTOR;
  logic tx_active_in = 1'h0, tx_valid_in = 1'h0, rx_ready_in = 1'h0, status_write_in = 1'h0, erase_req_in = 1'h0;
  logic [7:0] tx_data_in = 8'h00, status_wdata_in = 8'h00, rx_data_out, cmd_out, status_out, got;
  logic [19:0] erase_addr_in = 20'h00000, erase_first_out, erase_last_out, ea, em;
  logic [23:0] addr_out, program_address_out;
  logic [8:0] program_count_out;
  logic tx_ready_out, rx_valid_out, cmd_valid_out, addr_valid_out, overrun_out, write_protect_out;
  logic status_write_ignored_out, erase_valid_out, standby_out, paused_out;
  int mismatches = 0, n_compared = 0, ln[4] = '{1, 2, 4, 1};
  logic [39:0] q_cmd[$], q_addr[$], q_rx[$], q_er[$];

  always #4 clock_in = ~clock_in;

  // Released lines: pull-ups on two and three, toggling on zero and one.
  always @(posedge clock_in) flip <= ~flip;
  for (genvar k = 0; k < 4; k++)
  begin : g_line
    assign line[k] = d_oe[k] ? d_out[k] : h_oe[k] ? h_val[k] : (k > 1) ? 1'h1 : flip ^ (k == 1);
  end

  qsf_host_model host (.clock_in, .line_in(line), .sck_out(sck), .cs_n_out(cs_n), .oe_out(h_oe), .val_out(h_val));

  qsf_flash_port uut (.clock_in, .srst_in, .sck_in(sck), .cs_n_in(cs_n), .data_line_zero_in(line[0]),
    .data_line_zero_out(d_out[0]), .data_line_zero_oe_out(d_oe[0]), .data_line_one_in(line[1]),
    .data_line_one_out(d_out[1]), .data_line_one_oe_out(d_oe[1]), .data_line_two_in(line[2]),
    .data_line_two_out(d_out[2]), .data_line_two_oe_out(d_oe[2]), .data_line_three_in(line[3]),
    .data_line_three_out(d_out[3]), .data_line_three_oe_out(d_oe[3]), .lane_mode_in, .tx_active_in, .tx_data_in,
    .tx_valid_in, .tx_ready_out, .rx_data_out, .rx_valid_out, .rx_ready_in, .cmd_out, .cmd_valid_out, .addr_out,
    .addr_valid_out, .program_address_out, .program_count_out, .overrun_out, .status_write_in, .status_wdata_in,
    .status_out, .write_protect_out, .status_write_ignored_out, .erase_req_in, .erase_kind_in, .erase_addr_in,
    .erase_first_out, .erase_last_out, .erase_valid_out, .standby_out, .paused_out);

  task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] seen);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic print_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict

  // Each result meets the oldest note, or an unknown.
  always @(posedge clock_in)
  begin
    if (cmd_valid_out)
      chk("cmd", q_cmd.size() > 0 ? q_cmd.pop_front() : 'x, 40'(cmd_out));
    if (addr_valid_out)
      chk("addr", q_addr.size() > 0 ? q_addr.pop_front() : 'x, 40'(addr_out));
    if (rx_valid_out && rx_ready_in)
      chk("rx", q_rx.size() > 0 ? q_rx.pop_front() : 'x, 40'(rx_data_out));
    if (erase_valid_out)
      chk("erase", q_er.size() > 0 ? q_er.pop_front() : 'x, {erase_first_out, erase_last_out});
    if (tx_ready_out)
      tx_valid_in <= 1'h0;
    rx_ready_in <= !hold_rx && 1'($urandom);
  end

  // Status write, checked a cycle later.
  task automatic st(input logic [7:0] v, input logic [7:0] e);
    status_write_in <= 1'h1;
    status_wdata_in <= v;
    @(posedge clock_in);
    status_write_in <= 1'h0;
    @(posedge clock_in);
    chk("status", 40'(e), 40'(status_out));
  endtask : st

  // Opcode, address, n data bytes; the first keep written bytes come back.
  task automatic frame(input int lanes, input logic [7:0] op, input logic [23:0] a, input int n, input bit rd,
                       input int keep);
    logic [7:0] v;
    lane_mode_in <= lanes == 4 ? QSF_LANE_QUAD : lanes == 2 ? QSF_LANE_DUAL : QSF_LANE_SINGLE;
    host.start();
    q_cmd.push_back(40'(op));
    q_addr.push_back(40'(a));
    host.xfer(lanes, op, 8, 0, got);
    for (int i = 16; i >= 0; i -= 8)
      host.xfer(lanes, a[i +: 8], 8, 0, got);
    tx_active_in <= rd;
    for (int i = 0; i < n; i++)
    begin
      v = 8'($urandom);
      if (rd)
      begin
        tx_data_in <= v;
        tx_valid_in <= 1'h1;
      end
      else if (i < keep)
        q_rx.push_back(40'(v));
      host.xfer(lanes, v, 8, rd, got);
      if (rd)
        chk("read", 40'(v), 40'(got));
    end
    repeat (5) @(posedge clock_in);
    if (!rd)
    begin
      chk("count", 40'(n), 40'(program_count_out));
      chk("paddr", 40'({a[23:8], 8'(a[7:0] + n)}), 40'(program_address_out));
    end
    host.stop();
    tx_active_in <= 1'h0;
  endtask : frame

  // Main sequence.
  initial
  begin
    void'($urandom(32'hFCD8));
    repeat (6) @(posedge clock_in);
    srst_in <= 1'h0;
    host.xfer(1, 8'hA5, 8, 0, got);
    chk("standby", 40'h1, 40'(standby_out));
    st(8'h80, 8'h80);
    host.set_pin(2, 1'h0, 1'h1);
    repeat (5) @(posedge clock_in);
    chk("protect", 40'h1, 40'(write_protect_out));
    st(8'h00, 8'h80);
    host.set_pin(2, 1'h1, 1'h1);
    repeat (5) @(posedge clock_in);
    st(8'h03, 8'h00);
    host.set_pin(2, 1'h0, 1'h0);
    host.start();
    q_cmd.push_back(40'h9C);
    host.xfer(1, 8'h9C, 4, 0, got);
    host.set_pin(3, 1'h0, 1'h1);
    repeat (4) @(posedge clock_in);
    chk("paused", 40'h1, 40'(paused_out));
    host.xfer(1, 8'h0F, 8, 0, got);
    host.set_pin(3, 1'h1, 1'h1);
    repeat (4) @(posedge clock_in);
    host.xfer(1, 8'hC0, 4, 0, got);
    host.stop();
    host.start();
    host.xfer(1, 8'hF0, 4, 0, got);
    host.stop();
    hold_rx <= 1'h1;
    frame(1, 8'h02, 24'h0100FE, 9, 0, 8);
    chk("overrun", 40'h1, 40'(overrun_out));
    hold_rx <= 1'h0;
    st(8'h40, 8'h40);
    for (int j = 0; j < 4; j++)
    begin
      host.idle_hi = (j == 3);
      frame(ln[j], 8'h32, 24'($urandom), 2, 0, 2);
      frame(ln[j], 8'h6B, 24'($urandom), 2, 1, 0);
    end
    for (int k = 0; k < 3; k++)
    begin
      ea = 20'($urandom);
      em = k == 0 ? 20'h00FFF : k == 1 ? 20'h0FFFF : 20'hFFFFF;
      q_er.push_back({ea & ~em, ea | em});
      erase_kind_in <= qsf_erase_type'(k);
      erase_addr_in <= ea;
      erase_req_in <= 1'h1;
      @(posedge clock_in);
    end
    erase_req_in <= 1'h0;
    repeat (100) @(posedge clock_in);
    chk("left", 40'h0, 40'(q_cmd.size() + q_addr.size() + q_rx.size() + q_er.size()));
    print_verdict();
  end

  // Watchdog, about fourteen times the run.
  initial
  begin
    #400000;
    mismatches++;
    print_verdict();
  end
endmodule : tb
